/* common/iosc_pkg.sv */
package iosc_pkg;
  // dedicated i/o region base (top 16 MB)
  localparam logic [31:0] IOSC_IO_REGION_BASE = 32'hFF000000;
  localparam logic [4:0]  IOSC_ST_BROADCAST   = 5'h1F;
  localparam logic [4:0]  IOSC_ST_IDLE        = 5'h00;
  localparam logic [4:0]  IOSC_ST_READ        = 5'h0A;
  localparam logic [4:0]  IOSC_ST_WRITE       = 5'h0B;
  // configuration bit positions
  localparam int IOSC_CFG_FPU = 0;
  localparam int IOSC_CFG_MMU = 1;
  localparam int IOSC_CFG_CUS = 2;
  // processor register selectors for load_proc_reg
  localparam logic [3:0] IOSC_PR_USER_STATUS_WORD = 4'h0;
  localparam logic [3:0] IOSC_PR_DCR  = 4'h1;
  localparam logic [3:0] IOSC_PR_BPC  = 4'h2;
  localparam logic [3:0] IOSC_PR_DSR  = 4'h3;
  localparam logic [3:0] IOSC_PR_CAR  = 4'h4;
  localparam logic [3:0] IOSC_PR_FP   = 4'h8;
  localparam logic [3:0] IOSC_PR_SP   = 4'h9;
  localparam logic [3:0] IOSC_PR_SB   = 4'hA;
  localparam logic [3:0] IOSC_PR_PSR  = 4'hD;
  localparam logic [3:0] IOSC_PR_INTB = 4'hE;
  localparam logic [3:0] IOSC_PR_CFG  = 4'hC;
  // instruction classes presented by the decoder
  localparam logic [3:0] IOSC_OP_OTHER   = 4'h0;
  localparam logic [3:0] IOSC_OP_CLRSTAT = 4'h1;
  localparam logic [3:0] IOSC_OP_SETSTAT = 4'h2;
  localparam logic [3:0] IOSC_OP_BPT     = 4'h3;
  localparam logic [3:0] IOSC_OP_CACHE_INVALIDATE    = 4'h4;
  localparam logic [3:0] IOSC_OP_DIAG    = 4'h5;
  localparam logic [3:0] IOSC_OP_FLAG    = 4'h6;
  localparam logic [3:0] IOSC_OP_LMR     = 4'h7;
  localparam logic [3:0] IOSC_OP_LPR     = 4'h8;
  localparam logic [3:0] IOSC_OP_RETURN_FROM_TRAP    = 4'h9;
  localparam logic [3:0] IOSC_OP_RETURN_FROM_INTERRUPT    = 4'hA;
  localparam logic [3:0] IOSC_OP_SVC     = 4'hB;
  localparam logic [3:0] IOSC_OP_FPU     = 4'hC;
  localparam logic [3:0] IOSC_OP_CUSTOM  = 4'hD;
  localparam logic [3:0] IOSC_OP_MMU     = 4'hE;
  localparam logic [1:0] IOSC_SZ_BYTE = 2'h0;
  localparam logic [1:0] IOSC_SZ_WORD = 2'h1;
  localparam logic [7:0] IOSC_DONT_CARE_BYTE = 8'h00;
endpackage : iosc_pkg

/* src/iosc_ctrl.sv */
// Function
// - peripheral reads and writes with side effects happen in program order
// - inhibit asserted on reads if speculative or an earlier write pends
// - decode with inhibit active: discard data and serialize
// - then repeat the same read with inhibit inactive
// - reads in top region wait while a write into it pends
// - region reads and low reads pass unrelated pending writes
// - inhibit may still be asserted inside the top region
// - serialize means drain all writes before next fetch
// - every exception serializes
// - listed system instructions serialize after execution
// - word load of status word flushes the pipeline
// - byte load of user status allowed in user mode, serializes
// - pending writes commit no later than next serialization
// - reset or fatal bus error drops pending writes
// - disabled slave instruction traps undefined with no bus activity
// - disabled mmu instruction traps, never uses slave protocol
// - slave instruction: id byte then two byte operation word
// - broadcast cycle status 11111, id byte on D24-D31
// - operation word byte swapped on D8-D23, D0-D7 unused
`timescale 1ns/100ps
`default_nettype none
module iosc_ctrl
  import iosc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // pipeline read request
  input  wire logic        rd_req,
  input  wire logic [31:0] rd_addr,
  input  wire logic        rd_speculative,
  output logic             rd_grant,
  output logic             rd_done,
  output logic [31:0]      rd_data,
  output logic             rd_discard,
  // write path (results from executed instructions)
  input  wire logic        wr_push,
  input  wire logic [31:0] wr_addr,
  input  wire logic [31:0] wr_data,
  output logic             wr_full,
  // bus
  output logic             bus_start,
  output logic [4:0]       bus_status,
  output logic [31:0]      bus_addr,
  output logic [31:0]      bus_dout,
  output logic             bus_write,
  input  wire logic        bus_rdy,
  input  wire logic [31:0] bus_din,
  input  wire logic        bus_fatal_err,
  output logic             io_inhibit_out,
  input  wire logic        io_decode_in,
  // instruction completion
  input  wire logic        instr_done,
  input  wire logic [3:0]  instr_class,
  input  wire logic [3:0]  instr_preg,
  input  wire logic [1:0]  instr_size,
  input  wire logic        user_mode,
  input  wire logic [23:0] slave_basic,
  input  wire logic [2:0]  cfg_enables,
  input  wire logic        exception_done,
  output logic             serializing,
  output logic             flush,
  output logic             trap_undef,
  output logic             trap_priv,
  output logic             slave_sent
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_WRITE = 5'b00010, S_READ = 5'b00100,
    S_SER  = 5'b01000, S_BCAST = 5'b10000
  } iosc_state_type;

  function automatic logic in_region(input logic [31:0] a);
    in_region = (a >= IOSC_IO_REGION_BASE);
  endfunction : in_region

  // two-deep write path, as the pipeline provides
  logic [31:0] wa_q [2];
  logic [31:0] wd_q [2];
  logic [1:0]  wcnt_q, wcnt_d;
  logic [31:0] wa0_d, wa1_d, wd0_d, wd1_d;
  iosc_state_type st_q, st_d;
  logic        ser_pend_q, ser_pend_d, retry_q, retry_d;
  logic        bc_pend_q, bc_pend_d;
  logic [23:0] bc_word_q, bc_word_d;
  logic        grant_d, done_d, disc_d, inh_d, start_d, wr_d, flush_d;
  logic        tu_d, tp_d, sent_d;
  logic [31:0] rdat_d, addr_d, dout_d;
  // read address kept so the repeat targets the same port after a drain
  logic [31:0] raddr_q, raddr_d;
  logic [4:0]  stat_d;
  logic        region_wr, ser_instr, lpr_ser, mmu_trap, slv_trap, slv_go;

  // which completing instruction serializes
  always_comb begin
    region_wr = (wcnt_q > 2'd0 && in_region(wa_q[0]))
             || (wcnt_q > 2'd1 && in_region(wa_q[1]));
    lpr_ser = instr_preg inside {IOSC_PR_CFG, IOSC_PR_INTB, IOSC_PR_PSR,
              IOSC_PR_USER_STATUS_WORD, IOSC_PR_DCR, IOSC_PR_BPC, IOSC_PR_DSR,
              IOSC_PR_CAR};
    // user mode may only use byte load of user status
    tp_d = instr_done && instr_class == IOSC_OP_LPR && user_mode
        && !(instr_preg == IOSC_PR_USER_STATUS_WORD && instr_size == IOSC_SZ_BYTE);
    mmu_trap = instr_class == IOSC_OP_MMU && !cfg_enables[IOSC_CFG_MMU];
    slv_trap = (instr_class == IOSC_OP_FPU && !cfg_enables[IOSC_CFG_FPU])
            || (instr_class == IOSC_OP_CUSTOM
                && !cfg_enables[IOSC_CFG_CUS]);
    tu_d = instr_done && (mmu_trap || slv_trap);
    slv_go = instr_done && !slv_trap && (instr_class == IOSC_OP_FPU
          || instr_class == IOSC_OP_CUSTOM);
    ser_instr = instr_done && !tp_d && (instr_class inside {
      IOSC_OP_CLRSTAT, IOSC_OP_SETSTAT, IOSC_OP_BPT, IOSC_OP_CACHE_INVALIDATE,
      IOSC_OP_DIAG, IOSC_OP_FLAG, IOSC_OP_LMR, IOSC_OP_RETURN_FROM_TRAP, IOSC_OP_RETURN_FROM_INTERRUPT,
      IOSC_OP_SVC} || (instr_class == IOSC_OP_LPR && lpr_ser));
    // word load of the status word refetches under new mode
    flush_d = ser_instr && instr_class == IOSC_OP_LPR
           && instr_preg == IOSC_PR_PSR && instr_size == IOSC_SZ_WORD;
  end

  // bus sequencer: writes drain in order, reads may pass them
  always_comb begin
    st_d = st_q; wcnt_d = wcnt_q;
    wa0_d = wa_q[0]; wa1_d = wa_q[1]; wd0_d = wd_q[0]; wd1_d = wd_q[1];
    ser_pend_d = ser_pend_q || ser_instr || exception_done;
    retry_d = retry_q; bc_pend_d = bc_pend_q || slv_go;
    bc_word_d = slv_go ? slave_basic : bc_word_q;
    grant_d = 1'b0; done_d = 1'b0; disc_d = 1'b0; start_d = 1'b0;
    rdat_d = rd_data; addr_d = bus_addr; dout_d = bus_dout;
    stat_d = bus_status; wr_d = bus_write; inh_d = io_inhibit_out;
    sent_d = 1'b0;
    raddr_d = raddr_q;
    unique case (st_q)
      S_IDLE: begin
        inh_d = 1'b0;
        if (bc_pend_q && wcnt_q == 2'd0) begin
          // broadcast id and swapped opword
          start_d = 1'b1; stat_d = IOSC_ST_BROADCAST; wr_d = 1'b1;
          dout_d = {bc_word_q[23:16], bc_word_q[7:0], bc_word_q[15:8],
                    IOSC_DONT_CARE_BYTE};
          st_d = S_BCAST;
        end else if (ser_pend_q || retry_q) begin
          st_d = S_SER;
        end else if (rd_req && !(in_region(rd_addr) && region_wr)) begin
          // region reads wait only for region writes
          start_d = 1'b1; stat_d = IOSC_ST_READ; wr_d = 1'b0;
          addr_d = rd_addr; grant_d = 1'b1;
          raddr_d = rd_addr;
          inh_d = rd_speculative || wcnt_q != 2'd0;
          st_d = S_READ;
        end else if (wcnt_q != 2'd0) begin
          start_d = 1'b1; stat_d = IOSC_ST_WRITE; wr_d = 1'b1;
          addr_d = wa_q[0]; dout_d = wd_q[0];
          st_d = S_WRITE;
        end
      end
      S_READ: if (bus_rdy) begin
        st_d = S_IDLE; inh_d = 1'b0; stat_d = IOSC_ST_IDLE;
        if (io_decode_in && io_inhibit_out) begin
          disc_d = 1'b1; retry_d = 1'b1;
        end else begin
          done_d = 1'b1; rdat_d = bus_din;
        end
      end
      S_WRITE: if (bus_rdy) begin
        st_d = S_IDLE; stat_d = IOSC_ST_IDLE;
        wa0_d = wa_q[1]; wd0_d = wd_q[1];
        // a fatal error may have emptied the path during this cycle
        if (wcnt_q != 2'd0) wcnt_d = wcnt_q - 2'd1;
      end
      S_SER: begin
        // drain every pending write before resuming
        if (wcnt_q != 2'd0) begin
          start_d = 1'b1; stat_d = IOSC_ST_WRITE; wr_d = 1'b1;
          addr_d = wa_q[0]; dout_d = wd_q[0]; st_d = S_WRITE;
        end else if (retry_q) begin
          // repeat read now ordered, inhibit inactive
          start_d = 1'b1; stat_d = IOSC_ST_READ; wr_d = 1'b0;
          inh_d = 1'b0; retry_d = 1'b0; addr_d = raddr_q;
          // a serializing completion in this cycle must not be lost
          ser_pend_d = ser_instr || exception_done;
          st_d = S_READ;
        end else begin
          ser_pend_d = ser_instr || exception_done; st_d = S_IDLE;
        end
      end
      S_BCAST: if (bus_rdy) begin
        st_d = S_IDLE; stat_d = IOSC_ST_IDLE; sent_d = 1'b1;
        bc_pend_d = slv_go;
      end
      default: st_d = S_IDLE;
    endcase
    // accept new write after drain accounting
    if (wr_push && wcnt_d != 2'd2) begin
      if (wcnt_d == 2'd0) begin wa0_d = wr_addr; wd0_d = wr_data; end
      else begin wa1_d = wr_addr; wd1_d = wr_data; end
      wcnt_d = wcnt_d + 2'd1;
    end
    // fatal error drops queued writes; a read in flight still completes
    if (bus_fatal_err) begin
      wcnt_d = 2'd0;
      if (st_d == S_WRITE && st_q != S_WRITE) begin
        // cancel a write launch whose data was just dropped
        st_d = S_IDLE; start_d = 1'b0; stat_d = bus_status;
        wr_d = bus_write; addr_d = bus_addr; dout_d = bus_dout;
      end
    end
  end

  // registers; reset discards pending writes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE; wcnt_q <= 2'd0;
      wa_q[0] <= 32'h0; wa_q[1] <= 32'h0; wd_q[0] <= 32'h0; wd_q[1] <= 32'h0;
      ser_pend_q <= 1'b0; retry_q <= 1'b0; bc_pend_q <= 1'b0;
      bc_word_q <= 24'h0; rd_grant <= 1'b0; rd_done <= 1'b0;
      raddr_q <= 32'h0;
      rd_data <= 32'h0; rd_discard <= 1'b0; bus_start <= 1'b0;
      bus_status <= IOSC_ST_IDLE; bus_addr <= 32'h0; bus_dout <= 32'h0;
      bus_write <= 1'b0; io_inhibit_out <= 1'b0; wr_full <= 1'b0;
      serializing <= 1'b0; flush <= 1'b0; trap_undef <= 1'b0;
      trap_priv <= 1'b0; slave_sent <= 1'b0;
    end else begin
      st_q <= st_d; wcnt_q <= wcnt_d;
      wa_q[0] <= wa0_d; wa_q[1] <= wa1_d; wd_q[0] <= wd0_d; wd_q[1] <= wd1_d;
      ser_pend_q <= ser_pend_d; retry_q <= retry_d; bc_pend_q <= bc_pend_d;
      bc_word_q <= bc_word_d; rd_grant <= grant_d; rd_done <= done_d;
      raddr_q <= raddr_d;
      rd_data <= rdat_d; rd_discard <= disc_d; bus_start <= start_d;
      bus_status <= stat_d; bus_addr <= addr_d; bus_dout <= dout_d;
      bus_write <= wr_d; io_inhibit_out <= inh_d;
      wr_full <= (wcnt_d == 2'd2);
      serializing <= ser_pend_d || retry_d; flush <= flush_d;
      trap_undef <= tu_d; trap_priv <= tp_d; slave_sent <= sent_d;
    end
  end

  // writes and broadcasts never carry the inhibit
  AST_NO_INH_ON_WRITE: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_start && bus_write |-> !io_inhibit_out)
    else $error("inhibit active on write");

  // a discarded read always leaves a serialization behind it
  AST_DISCARD_RETRY: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_discard |-> serializing && !rd_done)
    else $error("discarded read without serialization");

  // completion of a broadcast follows a cycle with the broadcast status
  AST_BCAST_STATUS: assert property (@(posedge clk_sys) disable iff (!nrst)
    slave_sent |-> $past(bus_status) == IOSC_ST_BROADCAST)
    else $error("broadcast without status 11111");

  // a trapped slave instruction must not queue a broadcast
  AST_TRAP_NO_BUS: assert property (@(posedge clk_sys) disable iff (!nrst)
    trap_undef |-> !$rose(bc_pend_q))
    else $error("trapped slave instruction scheduled");

  // the repeated read goes out with the inhibit released
  AST_RETRY_NO_INH: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_start && $fell(retry_q) |-> !io_inhibit_out)
    else $error("repeated read still inhibited");

  // a region read never launches over a pending region write
  AST_REGION_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_start && !bus_write && in_region(bus_addr)
    |-> !$past(region_wr))
    else $error("region read passed region write");

  // any pending write makes a launched read inhibited
  AST_INH_PENDING: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_start && !bus_write && $past(wcnt_q) != 2'd0
    |-> io_inhibit_out)
    else $error("read over pending write not inhibited");

  // opword bytes swapped, low lane carries the filler byte
  AST_BCAST_LANES: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_start && bus_status == IOSC_ST_BROADCAST
    |-> bus_dout[7:0] == IOSC_DONT_CARE_BYTE
        && bus_dout[15:8] == $past(bc_word_q[15:8])
        && bus_dout[23:16] == $past(bc_word_q[7:0]))
    else $error("broadcast lanes wrong");

  // the two-deep path can never underflow or overflow
  AST_WCNT_RANGE: assert property (@(posedge clk_sys) disable iff (!nrst)
    wcnt_q != 2'd3)
    else $error("write path count out of range");

  // a flush always comes with a serialization
  AST_FLUSH_SER: assert property (@(posedge clk_sys) disable iff (!nrst)
    flush |-> serializing)
    else $error("flush without serialization");

  // a granted read starts its bus cycle at once
  AST_GRANT_START: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_grant |-> bus_start && !bus_write
                 && bus_status == IOSC_ST_READ)
    else $error("grant without read cycle");

  // fatal error leaves the write path empty
  AST_DROP_ON_FATAL: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_fatal_err |=> wcnt_q == 2'd0 && !wr_full)
    else $error("writes survive fatal error");
endmodule : iosc_ctrl
`default_nettype wire

/* tb/iosc_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none
// stand-in for decoder, peripherals and one slave; answer delay is set live
module iosc_bus_model
  import iosc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  wait_cyc,
  input  wire logic        bus_start,
  input  wire logic [4:0]  bus_status,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_dout,
  output logic             bus_rdy,
  output logic [31:0]      bus_din,
  output logic             io_decode_in,
  output logic             id_match
);
  localparam logic [7:0] SLAVE_ID = 8'h5A; // arbitrary slave id
  logic [3:0] cnt_q;
  logic       busy_q;
  // data lines toggle while released so a stale value never looks valid
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_q       <= 1'b0;
      cnt_q        <= 4'h0;
      bus_rdy      <= 1'b0;
      bus_din      <= 32'h0;
      io_decode_in <= 1'b0;
      id_match     <= 1'b0;
    end else begin
      bus_rdy      <= 1'b0;
      io_decode_in <= 1'b0;
      bus_din      <= ~bus_din;
      if (bus_start) begin
        busy_q <= 1'b1;
        cnt_q  <= wait_cyc;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q       <= 1'b0;
        bus_rdy      <= 1'b1;
        bus_din      <= bus_addr ^ 32'hA5A5A5A5;
        io_decode_in <= (bus_addr[31:28] == 4'hC);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
      if (bus_start && bus_status == IOSC_ST_BROADCAST)
        id_match <= (bus_dout[31:24] == SLAVE_ID);
    end
  end
endmodule : iosc_bus_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import iosc_pkg::*;
  logic clk_sys, nrst, rd_req, rd_speculative, rd_grant, rd_done, rd_discard;
  logic wr_push, wr_full, bus_start, bus_write, bus_rdy, bus_fatal_err;
  logic io_inhibit_out, io_decode_in, instr_done, user_mode, exception_done;
  logic serializing, flush, trap_undef, trap_priv, slave_sent, id_match;
  logic [31:0] rd_addr, rd_data, wr_addr, wr_data, bus_addr, bus_dout, bus_din;
  logic [31:0] bc_dout;
  logic [4:0]  bus_status;
  logic [3:0]  instr_class, instr_preg, wait_cyc;
  logic [1:0]  instr_size;
  logic [23:0] slave_basic;
  logic [2:0]  cfg_enables;
  int miscompares, check_count, n_wr, n_rd, n_bc, n_io, n_ser, n_fl, n_tu;
  int n_tp, n_ss, wr_at_rd, i, n_dc;
  logic inh_at, ser_prev;
  iosc_ctrl DUT (.*);
  iosc_bus_model PEER (.clk_sys, .nrst, .wait_cyc, .bus_start, .bus_status,
    .bus_addr, .bus_dout, .bus_rdy, .bus_din, .io_decode_in, .id_match);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // bus and event tallies; sampled values are those of the launching cycle
  always @(posedge clk_sys) if (nrst) begin
    if (bus_start && bus_write) n_wr++;
    if (bus_start && !bus_write && bus_status == IOSC_ST_READ) begin
      n_rd++;
      wr_at_rd = n_wr;
      inh_at = io_inhibit_out;
    end
    if (bus_start && bus_status == IOSC_ST_BROADCAST) begin
      n_bc++;
      bc_dout = bus_dout;
    end
    if (bus_rdy && io_decode_in && !io_inhibit_out) n_io++;
    if (serializing && !ser_prev) n_ser++;
    ser_prev = serializing;
    n_fl += flush;
    n_tu += trap_undef;
    n_tp += trap_priv;
    n_ss += slave_sent;
    n_dc += rd_discard;
  end
  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic rd(input logic [31:0] a, input logic sp);
    @(posedge clk_sys);
    rd_addr <= a;
    rd_speculative <= sp;
    rd_req <= 1'b1;
    for (i = 0; i < 200 && rd_grant !== 1'b1; i++) @(posedge clk_sys);
    rd_req <= 1'b0;
    for (i = 0; i < 200 && rd_done !== 1'b1; i++) @(posedge clk_sys);
    chk(rd_data === (a ^ 32'hA5A5A5A5), "read data wrong");
  endtask : rd
  task automatic ins(input logic [3:0] c, p, input logic [1:0] s,
                     input logic u);
    @(posedge clk_sys);
    {instr_class, instr_preg, instr_size, user_mode} <= {c, p, s, u};
    instr_done <= 1'b1;
    @(posedge clk_sys);
    instr_done <= 1'b0;
    repeat (30) @(posedge clk_sys);
  endtask : ins
  task automatic push(input logic [31:0] a);
    @(posedge clk_sys);
    {wr_addr, wr_data, wr_push} <= {a, ~a, 1'b1};
    @(posedge clk_sys);
    wr_push <= 1'b0;
  endtask : push
  task automatic t_reads;
    int io0, d0;
    rd(32'h00001000, 1'b0);
    chk(inh_at === 1'b0, "inhibit on ordered read");
    {io0, d0} = {n_io, n_dc};
    rd(32'hC0000010, 1'b1);
    chk(n_dc == d0 + 1, "inhibited io read not discarded");
    chk(inh_at === 1'b0 && n_io == io0 + 1,
        "io read not repeated once");
    push(32'hFF000100);
    rd(32'hFF000200, 1'b0);
    chk(wr_at_rd == n_wr, "region read passed region write");
    $display("test reads done");
  endtask : t_reads
  task automatic t_serial;
    logic [3:0] pr [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hC, 4'hD, 4'hE,
                            4'h8, 4'h9, 4'hA};
    int s0, w0;
    for (int c = 0; c < 12; c++) if (c != 8) begin
      s0 = n_ser;
      w0 = n_wr;
      push(32'h00002000);
      ins(c[3:0], 4'h0, IOSC_SZ_WORD, 1'b0);
      chk((n_ser > s0) == (c != 0), "serialize on class");
      chk(n_wr == w0 + 1, "write not drained");
    end
    for (int k = 0; k < 11; k++) begin
      s0 = n_ser;
      ins(IOSC_OP_LPR, pr[k], IOSC_SZ_WORD, 1'b0);
      chk((n_ser > s0) == (k < 8), "serialize on target");
    end
    s0 = n_fl;
    ins(IOSC_OP_LPR, IOSC_PR_PSR, IOSC_SZ_WORD, 1'b0);
    chk(n_fl > s0, "no flush on status load");
    {s0, w0} = {n_ser, n_tp};
    ins(IOSC_OP_LPR, IOSC_PR_USER_STATUS_WORD, IOSC_SZ_BYTE, 1'b1);
    chk(n_ser > s0 && n_tp == w0, "user byte load");
    {s0, w0} = {n_ser, n_tp};
    ins(IOSC_OP_LPR, IOSC_PR_PSR, IOSC_SZ_WORD, 1'b1);
    chk(n_tp == w0 + 1 && n_ser == s0, "user word load");
    s0 = n_ser;
    @(posedge clk_sys) exception_done <= 1'b1;
    @(posedge clk_sys) exception_done <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk(n_ser > s0, "no serialize on exception");
    $display("test serial done");
  endtask : t_serial
  task automatic t_slave;
    int b0, u0;
    slave_basic <= 24'h5A3C81;
    for (int m = 0; m < 2; m++) begin
      cfg_enables <= m ? 3'h7 : 3'h0;
      {b0, u0} = {n_bc, n_tu};
      ins(IOSC_OP_FPU, 4'h0, IOSC_SZ_WORD, 1'b0);
      chk((n_bc > b0) == m && (n_tu > u0) == !m, "fpu enable");
      {b0, u0} = {n_bc, n_tu};
      ins(IOSC_OP_MMU, 4'h0, IOSC_SZ_WORD, 1'b0);
      chk(n_bc == b0 && (n_tu > u0) == !m, "mmu enable");
    end
    ins(IOSC_OP_CUSTOM, 4'h0, IOSC_SZ_WORD, 1'b0);
    chk(bc_dout[31:8] === 24'h5A813C && n_ss > 0, "broadcast word");
    chk(id_match === 1'b1, "id byte lane");
    $display("test slave done");
  endtask : t_slave
  task automatic t_fatal;
    int w0;
    wait_cyc <= 4'hC;
    fork
      rd(32'h00003000, 1'b0);
      begin
        repeat (3) @(posedge clk_sys);
        push(32'h00004000);
        push(32'h00005000);
        @(posedge clk_sys);
        chk(wr_full === 1'b1, "write path not full");
        w0 = n_wr;
        bus_fatal_err <= 1'b1;
        @(posedge clk_sys) bus_fatal_err <= 1'b0;
      end
    join
    wait_cyc <= 4'h1;
    repeat (40) @(posedge clk_sys);
    chk(n_wr == w0, "dropped write still issued");
    chk(wr_full === 1'b0, "full flag survives fatal error");
    $display("test fatal done");
  endtask : t_fatal
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    {nrst, rd_req, rd_speculative, wr_push, bus_fatal_err} = '0;
    {instr_done, user_mode, exception_done, rd_addr, wr_addr} = '0;
    {wr_data, instr_class, instr_preg, instr_size} = '0;
    {slave_basic, cfg_enables, wait_cyc} = {24'h0, 3'h7, 4'h1};
    n_dc = 0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reads();
    t_serial();
    t_slave();
    t_fatal();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
